// File: src/sp_cfg.svh
/*
 * Constants of the four-mode serial port: register addresses, bit
 * positions, reset values and rate divisors.
 * Assumes inclusion by bare name from the serial port sources.
 */
`ifndef SP_CFG_SVH
`define SP_CFG_SVH
`define SP_ADDR_CONTROL 8'h98
`define SP_ADDR_DATA 8'h99
`define SP_ADDR_POWER 8'h87
`define SP_CONTROL_RESET 8'h00
`define SP_BIT_MODE_HI 7
`define SP_BIT_MODE_LO 6
`define SP_BIT_MULTI 5
`define SP_BIT_RX_EN 4
`define SP_BIT_TX_NINTH 3
`define SP_BIT_RX_NINTH 2
`define SP_BIT_TX_DONE 1
`define SP_BIT_RX_DONE 0
`define SP_BIT_RATE_DOUBLE 7
`define SP_M0_DIV 12
`define SP_M2_DIV_SLOW 64
`define SP_M2_DIV_FAST 32
`define SP_OVERSAMPLE 16
`define SP_MID_SAMPLE 4'h7
`define SP_NINTH_SAMPLE 4'h9
`define SP_MODE1_SAMPLES 4'h9
`define SP_MODE23_SAMPLES 4'ha
`endif

// File: src/sp_pkg.sv
/*
 * Types of the four-mode serial port: mode encoding and the state
 * records of the processor side and of the line side.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package sp_pkg;
    // mode order follows the two mode select bits
    typedef enum logic [1:0] {SP_MODE_SHIFT, SP_MODE_8BIT, SP_MODE_9BIT_FIXED,
        SP_MODE_9BIT_VAR} sp_mode_t;

    // processor clock side
    typedef struct packed {
        logic [7:0] control;
        logic rate_double;
        logic [7:0] tx_buf;
        logic [7:0] rx_buf;
        logic tx_tog;
        logic t1_tog;
        logic rx_seen;
        logic done_seen;
        logic [7:0] rdata;
        logic irq;
    } sp_cpu_state_t;

    // line clock side
    typedef struct packed {
        logic [5:0] pre;
        logic t1_half;
        logic t1_last;
        logic tick;
        logic tx_busy;
        logic [10:0] tx_sh;
        logic [3:0] tx_bits;
        logic [3:0] tx_cnt;
        logic tx_seen;
        logic done_tog;
        logic txd;
        logic m0_busy;
        logic m0_rx;
        logic m0_wait;
        logic [7:0] m0_sh;
        logic [3:0] m0_bits;
        logic [3:0] m0_ph;
        logic sclk;
        logic rxd_out;
        logic rxd_oe;
        logic rx_busy;
        logic [3:0] rx_cnt;
        logic [3:0] rx_bits;
        logic [7:0] rx_sh;
        logic rx_last;
        logic [7:0] rx_data;
        logic rx_nine;
        logic rx_tog;
    } sp_line_state_t;
endpackage

// File: src/sp_sync.sv
/*
 * Two flip-flop synchroniser for a vector of independent levels.
 * Assumes each bit is a level or a toggle that holds for several cycles.
 */
`timescale 1ns/10ps
`default_nettype none
module sp_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset of the receiving domain
    input wire logic clk,
    input wire logic reset_n,
    // levels in and out
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
    } sp_sync_state_t;

    sp_sync_state_t s;
    sp_sync_state_t next_s;

    // first stage feeds only the second
    always_comb
    begin
        next_s.s1 = d;
        next_s.s2 = s.s1;
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            s <= '0;
        else
            s <= next_s;
    end

    assign q = s.s2;
endmodule
`default_nettype wire

// File: src/sp_serial_port.sv
/*
 * Four-mode serial port: control, power and data buffer registers on
 * the special function register port, shift engines on the line clock.
 * Assumes line_clk is the oscillator, timer1_overflow is a one-cycle
 * pulse on ref_clk, and an outside resolver joins rxd_out/rxd_oe.
 */
`timescale 1ns/10ps
`default_nettype none
`include "sp_cfg.svh"
module sp_serial_port (
    // processor clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // special function register port
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    // baud source and interrupt request
    input wire logic timer1_overflow,
    output logic serial_irq,
    // line side
    input wire logic line_clk,
    input wire logic rxd_in,
    output logic rxd_out,
    output logic rxd_oe,
    output logic txd_out
);
    import sp_pkg::*;

    sp_cpu_state_t c;
    sp_cpu_state_t next_c;
    sp_line_state_t l;
    sp_line_state_t next_l;
    logic [1:0] cpu_s;
    logic [8:0] line_s;
    logic cs_rx_tog;
    logic cs_done_tog;
    logic ls_tx_tog;
    logic ls_t1_tog;
    logic [1:0] ls_mode;
    logic ls_ren;
    logic ls_tb8;
    logic ls_ri;
    logic ls_rate;
    logic ls_rxd;
    logic rx_ev;
    logic done_ev;
    logic rx_accept;
    sp_mode_t cmode;
    sp_mode_t lmode;

    // line events into the processor domain
    sp_sync #(.WIDTH(2)) u_to_cpu (
        .clk(ref_clk),
        .reset_n(reset_n),
        .d({l.rx_tog, l.done_tog}),
        .q(cpu_s)
    );

    // controls, request toggles and the data pin into the line domain
    sp_sync #(.WIDTH(9)) u_to_line (
        .clk(line_clk),
        .reset_n(reset_n),
        .d({c.tx_tog, c.t1_tog, c.control[`SP_BIT_MODE_HI:`SP_BIT_MODE_LO],
            c.control[`SP_BIT_RX_EN], c.control[`SP_BIT_TX_NINTH],
            c.control[`SP_BIT_RX_DONE], c.rate_double, rxd_in}),
        .q(line_s)
    );

    assign {cs_rx_tog, cs_done_tog} = cpu_s;
    assign {ls_tx_tog, ls_t1_tog, ls_mode, ls_ren, ls_tb8, ls_ri, ls_rate, ls_rxd} = line_s;
    assign rx_ev = cs_rx_tog != c.rx_seen;
    assign done_ev = cs_done_tog != c.done_seen;
    assign cmode = sp_mode_t'(c.control[`SP_BIT_MODE_HI:`SP_BIT_MODE_LO]);
    assign lmode = sp_mode_t'(ls_mode);
    // unread byte or filtered frame is dropped
    assign rx_accept = !c.control[`SP_BIT_RX_DONE] && (cmode == SP_MODE_SHIFT
        || !c.control[`SP_BIT_MULTI] || l.rx_nine);

    // register port, flags and crossing toggles
    always_comb
    begin
        next_c = c;
        // buffer write loads transmit side and requests a frame
        if (sfr_wr)
        begin
            case (sfr_addr)
                `SP_ADDR_CONTROL: next_c.control = sfr_wdata;
                `SP_ADDR_DATA:
                begin
                    next_c.tx_buf = sfr_wdata;
                    next_c.tx_tog = ~c.tx_tog;
                end
                `SP_ADDR_POWER: next_c.rate_double = sfr_wdata[`SP_BIT_RATE_DOUBLE];
                default: next_c.rdata = c.rdata;
            endcase
        end
        if (timer1_overflow)
            next_c.t1_tog = ~c.t1_tog;
        // hardware set wins over a software clear
        if (done_ev)
        begin
            next_c.done_seen = cs_done_tog;
            next_c.control[`SP_BIT_TX_DONE] = 1'b1;
        end
        if (rx_ev)
        begin
            next_c.rx_seen = cs_rx_tog;
            if (rx_accept)
            begin
                next_c.rx_buf = l.rx_data;
                next_c.control[`SP_BIT_RX_DONE] = 1'b1;
                // ninth bit or stop bit lands in the field
                if (cmode != SP_MODE_SHIFT)
                    next_c.control[`SP_BIT_RX_NINTH] = l.rx_nine;
            end
        end
        // reads see the separate receive register
        if (sfr_rd)
        begin
            case (sfr_addr)
                `SP_ADDR_CONTROL: next_c.rdata = c.control;
                `SP_ADDR_DATA: next_c.rdata = c.rx_buf;
                `SP_ADDR_POWER: next_c.rdata = {c.rate_double, 7'h00};
                default: next_c.rdata = 8'h00;
            endcase
        end
        next_c.irq = next_c.control[`SP_BIT_RX_DONE] | next_c.control[`SP_BIT_TX_DONE];
    end

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            c <= '0;
            c.control <= `SP_CONTROL_RESET;
        end
        else
            c <= next_c;
    end

    assign sfr_rdata = c.rdata;
    assign serial_irq = c.irq;

    // shift engines on the oscillator clock
    always_comb
    begin
        next_l = l;
        next_l.tick = 1'b0;
        next_l.t1_last = ls_t1_tog;
        // fixed rate, sixteen samples per bit
        if (lmode == SP_MODE_9BIT_FIXED)
        begin
            if (l.pre >= 6'((ls_rate ? `SP_M2_DIV_FAST : `SP_M2_DIV_SLOW)
                / `SP_OVERSAMPLE - 1))
            begin
                next_l.pre = 6'h00;
                next_l.tick = 1'b1;
            end
            else
                next_l.pre = l.pre + 6'h01;
        end
        // timer 1 overflows, halved unless doubled
        else if (ls_t1_tog != l.t1_last)
        begin
            next_l.t1_half = ~l.t1_half;
            next_l.tick = ls_rate | l.t1_half;
        end

        // frame build for the asynchronous modes
        if (ls_tx_tog != l.tx_seen && lmode != SP_MODE_SHIFT && !l.tx_busy)
        begin
            next_l.tx_seen = ls_tx_tog;
            next_l.tx_busy = 1'b1;
            next_l.tx_cnt = 4'h0;
            // ninth bit taken from the control field
            if (lmode == SP_MODE_8BIT)
            begin
                next_l.tx_sh = {2'b11, c.tx_buf, 1'b0};
                next_l.tx_bits = 4'ha;
            end
            else
            begin
                next_l.tx_sh = {1'b1, ls_tb8, c.tx_buf, 1'b0};
                next_l.tx_bits = 4'hb;
            end
        end
        else if (l.tx_busy && l.tick)
        begin
            next_l.tx_cnt = l.tx_cnt + 4'h1;
            if (l.tx_cnt == 4'hf)
            begin
                next_l.tx_sh = {1'b1, l.tx_sh[10:1]};
                next_l.tx_bits = l.tx_bits - 4'h1;
                if (l.tx_bits == 4'h1)
                begin
                    next_l.tx_busy = 1'b0;
                    next_l.done_tog = ~l.done_tog;
                end
            end
        end

        if (lmode != SP_MODE_SHIFT)
            next_l.m0_wait = 1'b0;
        else if (l.m0_wait && ls_ri)
            next_l.m0_wait = 1'b0;
        if (lmode == SP_MODE_SHIFT && !l.m0_busy)
        begin
            next_l.m0_bits = 4'h0;
            next_l.m0_ph = 4'h0;
            if (ls_tx_tog != l.tx_seen)
            begin
                next_l.tx_seen = ls_tx_tog;
                next_l.m0_busy = 1'b1;
                next_l.m0_rx = 1'b0;
                next_l.m0_sh = c.tx_buf;
            end
            else if (ls_ren && !ls_ri && !l.m0_wait)
            begin
                next_l.m0_busy = 1'b1;
                next_l.m0_rx = 1'b1;
            end
        end
        else if (l.m0_busy)
        begin
            next_l.m0_ph = l.m0_ph + 4'h1;
            // sample just before the rising clock edge
            if (l.m0_rx && l.m0_ph == 4'(`SP_M0_DIV / 2 - 1))
                next_l.m0_sh = {ls_rxd, l.m0_sh[7:1]};
            if (l.m0_ph == 4'(`SP_M0_DIV - 1))
            begin
                next_l.m0_ph = 4'h0;
                next_l.m0_bits = l.m0_bits + 4'h1;
                if (!l.m0_rx)
                    next_l.m0_sh = {1'b1, l.m0_sh[7:1]};
                if (l.m0_bits == 4'h7)
                begin
                    next_l.m0_busy = 1'b0;
                    if (l.m0_rx)
                    begin
                        next_l.rx_data = l.m0_sh;
                        next_l.rx_tog = ~l.rx_tog;
                        next_l.m0_wait = 1'b1;
                    end
                    else
                        next_l.done_tog = ~l.done_tog;
                end
            end
        end

        // asynchronous receiver, runs beside the transmitter
        next_l.rx_last = ls_rxd;
        if (!l.rx_busy)
        begin
            if (ls_ren && lmode != SP_MODE_SHIFT && l.rx_last && !ls_rxd)
            begin
                next_l.rx_busy = 1'b1;
                next_l.rx_cnt = 4'h0;
                next_l.rx_bits = 4'h0;
            end
        end
        else if (l.tick)
        begin
            next_l.rx_cnt = l.rx_cnt + 4'h1;
            if (l.rx_cnt == `SP_MID_SAMPLE)
            begin
                next_l.rx_bits = l.rx_bits + 4'h1;
                // false start bit is dropped
                if (l.rx_bits == 4'h0 && ls_rxd)
                    next_l.rx_busy = 1'b0;
                else if (l.rx_bits != 4'h0 && l.rx_bits < `SP_NINTH_SAMPLE)
                    next_l.rx_sh = {ls_rxd, l.rx_sh[7:1]};
                else if (l.rx_bits == `SP_NINTH_SAMPLE)
                    next_l.rx_nine = ls_rxd;
                // stop kept in mode 1, ignored in modes 2 and 3
                if (l.rx_bits == (lmode == SP_MODE_8BIT ? `SP_MODE1_SAMPLES
                    : `SP_MODE23_SAMPLES))
                begin
                    next_l.rx_busy = 1'b0;
                    next_l.rx_data = l.rx_sh;
                    next_l.rx_tog = ~l.rx_tog;
                end
            end
        end

        // pin drive from the next state
        next_l.sclk = !(next_l.m0_busy && next_l.m0_ph < 4'(`SP_M0_DIV / 2));
        next_l.rxd_oe = next_l.m0_busy && !next_l.m0_rx;
        next_l.rxd_out = next_l.rxd_oe ? next_l.m0_sh[0] : 1'b1;
        if (lmode == SP_MODE_SHIFT)
            next_l.txd = next_l.sclk;
        else
            next_l.txd = next_l.tx_busy ? next_l.tx_sh[0] : 1'b1;
    end

    always_ff @(posedge line_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            l <= '0;
            l.txd <= 1'b1;
            l.sclk <= 1'b1;
            l.rxd_out <= 1'b1;
        end
        else
            l <= next_l;
    end

    assign txd_out = l.txd;
    assign rxd_out = l.rxd_out;
    assign rxd_oe = l.rxd_oe;

    // checks on the processor side
    property p_write_starts;
        @(posedge ref_clk) disable iff (!reset_n)
        sfr_wr && sfr_addr == `SP_ADDR_DATA |=> c.tx_tog != $past(c.tx_tog);
    endproperty
    a_write_starts: assert property (p_write_starts)
        else $error("data write did not request a frame");

    property p_split_buffer;
        @(posedge ref_clk) disable iff (!reset_n)
        sfr_wr && sfr_addr == `SP_ADDR_DATA && !rx_ev
        |=> $stable(c.rx_buf) && c.tx_buf == $past(sfr_wdata);
    endproperty
    a_split_buffer: assert property (p_split_buffer)
        else $error("data write disturbed the receive register");

    property p_overrun_drop;
        @(posedge ref_clk) disable iff (!reset_n)
        rx_ev && c.control[`SP_BIT_RX_DONE] |=> $stable(c.rx_buf);
    endproperty
    a_overrun_drop: assert property (p_overrun_drop)
        else $error("unread byte was overwritten");

    property p_flag_sticky;
        @(posedge ref_clk) disable iff (!reset_n)
        c.control[`SP_BIT_TX_DONE] && !(sfr_wr && sfr_addr == `SP_ADDR_CONTROL)
        |=> c.control[`SP_BIT_TX_DONE] && serial_irq;
    endproperty
    a_flag_sticky: assert property (p_flag_sticky)
        else $error("transmit flag dropped without a write");

    property p_multi_filter;
        @(posedge ref_clk) disable iff (!reset_n)
        rx_ev && !c.control[`SP_BIT_RX_DONE] && c.control[`SP_BIT_MULTI]
        && cmode != SP_MODE_SHIFT && !l.rx_nine
        && !(sfr_wr && sfr_addr == `SP_ADDR_CONTROL) |=> !c.control[`SP_BIT_RX_DONE];
    endproperty
    a_multi_filter: assert property (p_multi_filter)
        else $error("filtered frame raised the receive flag");

    // checks on the line side
    property p_shift_clock;
        @(posedge line_clk) disable iff (!reset_n)
        $fell(l.sclk) |-> (!l.sclk)[*6] ##1 l.sclk[*6];
    endproperty
    a_shift_clock: assert property (p_shift_clock)
        else $error("shift clock period is not twelve clocks");

    property p_shift_drive;
        @(posedge line_clk) disable iff (!reset_n)
        l.m0_busy |-> l.rxd_oe == !l.m0_rx;
    endproperty
    a_shift_drive: assert property (p_shift_drive)
        else $error("data pin drive wrong for shift direction");

    property p_shift_rx_start;
        @(posedge line_clk) disable iff (!reset_n)
        $rose(l.m0_busy) && l.m0_rx |-> $past(ls_ren) && !$past(ls_ri);
    endproperty
    a_shift_rx_start: assert property (p_shift_rx_start)
        else $error("shift reception began without enable");

    property p_async_start;
        @(posedge line_clk) disable iff (!reset_n)
        $rose(l.rx_busy) |-> $past(ls_ren) && !$past(ls_rxd);
    endproperty
    a_async_start: assert property (p_async_start)
        else $error("reception began without enable or start bit");

    property p_ninth_sent;
        @(posedge line_clk) disable iff (!reset_n)
        $rose(l.tx_busy) && lmode[1] |-> l.tx_sh[9] == $past(ls_tb8) && !l.txd;
    endproperty
    a_ninth_sent: assert property (p_ninth_sent)
        else $error("ninth bit or start bit wrong");

    property p_stop_bit;
        @(posedge line_clk) disable iff (!reset_n)
        l.tx_busy && l.tx_bits == 4'h1 && lmode != SP_MODE_SHIFT |-> l.txd;
    endproperty
    a_stop_bit: assert property (p_stop_bit)
        else $error("stop bit not high");
endmodule
`default_nettype wire

// File: sim/sp_peer.sv
/*
 * serial peer: uart frames and a mode 0 shift register.
 * assumes the bench joins drv with rxd_out by rxd_oe.
 */
`timescale 1ns/10ps
`default_nettype none
module sp_peer (
    // pins seen from the far side
    input wire logic txd_out,
    input wire logic rxd_out,
    input wire logic rxd_oe,
    output logic drv
);
    // idle line is pulled high
    initial drv = 1'b1;

    task automatic send(input int n, input logic [10:0] f, input int b);
        for (int i = 0; i < n; i++)
        begin
            drv = f[i];
            #(b);
        end
        drv = 1'b1;
    endtask

    // sample every bit of a frame mid-bit
    task automatic recv(input int n, input int b, output logic [10:0] f);
        f = '1;
        @(negedge txd_out);
        #(b / 2);
        for (int i = 0; i < n; i++)
        begin
            f[i] = txd_out;
            if (i < n - 1)
                #(b);
        end
    endtask

    // mode 0 capture on rising shift clock, undriven pin reads inverted
    task automatic m0_cap(output logic [7:0] v, output int per);
        realtime t0;
        for (int i = 0; i < 8; i++)
        begin
            @(posedge txd_out);
            v[i] = rxd_oe ? rxd_out : ~rxd_out;
            if (i == 0)
                t0 = $realtime;
            if (i == 1)
                per = int'($realtime - t0);
        end
    endtask

    // mode 0 feed: next bit after each rising clock
    task automatic m0_feed(input logic [7:0] v);
        drv = v[0];
        for (int i = 1; i < 8; i++)
        begin
            @(posedge txd_out);
            drv = v[i];
        end
        @(posedge txd_out);
        drv = 1'b1;
    endtask
endmodule
`default_nettype wire

// File: sim/tb_serial_port_four_mode.sv
/*
 * bench of the four-mode serial port against the peer model.
 * assumes the port's own assertions guard its internals.
 */
`timescale 1ns/10ps
`default_nettype none
`include "sp_cfg.svh"
module tb_serial_port_four_mode;
    logic ref_clk = 1'b0;
    logic line_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] wdata = 8'h00;
    logic t1 = 1'b0;
    logic [1:0] t1_cnt = 2'h0;
    logic [7:0] rdata;
    logic irq, rxd_out, rxd_oe, txd_out, drv, rxd_in;
    int errors = 0;
    int checked = 0;

    // pin level: port drives only in mode 0 transmit
    assign rxd_in = rxd_oe ? rxd_out : drv;

    sp_serial_port u_sp_serial_port (.ref_clk(ref_clk), .reset_n(reset_n), .sfr_addr(addr),
        .sfr_wr(wr), .sfr_rd(rd), .sfr_wdata(wdata), .sfr_rdata(rdata),
        .timer1_overflow(t1), .serial_irq(irq), .line_clk(line_clk), .rxd_in(rxd_in),
        .rxd_out(rxd_out), .rxd_oe(rxd_oe), .txd_out(txd_out));
    sp_peer u_sp_peer (.txd_out(txd_out), .rxd_out(rxd_out), .rxd_oe(rxd_oe), .drv(drv));

    // clocks, line clock out of phase
    always #25 ref_clk = ~ref_clk;
    initial
    begin
        #3.7;
        forever #6 line_clk = ~line_clk;
    end

    // baud source: one overflow every 4 cycles
    always @(posedge ref_clk)
    begin
        t1 <= #1 (t1_cnt == 2'h3);
        t1_cnt <= t1_cnt + 2'h1;
    end

    // bit time in ns
    function automatic int bit_ns(input int m, input logic sd);
        if (m == 2)
            return sd ? 32 * 12 : 64 * 12;
        return 16 * (sd ? 1 : 2) * 4 * 50;
    endfunction

    task automatic chk(input string s, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp)
        begin
            errors++;
            $display("[ERR] %s expected %h seen %h", s, exp, seen);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        #1;
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(posedge ref_clk);
        #1;
        wr = 1'b0;
    endtask

    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        #1;
        addr = a;
        rd = 1'b1;
        @(posedge ref_clk);
        #1;
        rd = 1'b0;
        d = rdata;
    endtask

    // poll a control flag, bounded
    task automatic wait_flag(input int i);
        logic [7:0] c;
        c = 8'h00;
        for (int k = 0; k < 3000 && c[i] !== 1'b1; k++)
            rd_reg(`SP_ADDR_CONTROL, c);
    endtask

    task automatic results();
        $display("errors %0d checked %0d", errors, checked);
        if (errors == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // watchdog
    initial
    begin
        #2_000_000;
        errors++;
        results();
    end

    // main sequence
    initial
    begin
        logic [7:0] c, d, e, last, v;
        logic [10:0] got;
        int m, per, b;
        logic sd, sm2, tb8, n9, st, keep, rb8, acc;
        void'($urandom(32'hb737));
        repeat (20) @(posedge ref_clk);
        #1;
        reset_n = 1'b1;
        rd_reg(`SP_ADDR_CONTROL, c);
        chk("control", c, `SP_CONTROL_RESET);
        chk("idle", {irq, rxd_oe, txd_out}, 3'h1);
        wr_reg(`SP_ADDR_POWER, 8'hff);
        rd_reg(`SP_ADDR_POWER, c);
        chk("power", c, 8'h80);
        rd_reg(8'h42, c);
        chk("unmapped", c, 8'h00);
        $display("test reset done");
        // mode 0 shift out, then shift in
        d = 8'($urandom);
        fork
            u_sp_peer.m0_cap(v, per);
            wr_reg(`SP_ADDR_DATA, d);
        join
        chk("m0_tx", v, d);
        chk("m0_bit", 16'(per), 16'h0090);
        wait_flag(1);
        rd_reg(`SP_ADDR_CONTROL, c);
        chk("m0_ctl", {irq, c}, 9'h102);
        e = 8'($urandom);
        fork
            u_sp_peer.m0_feed(e);
            wr_reg(`SP_ADDR_CONTROL, 8'h10);
        join
        wait_flag(0);
        rd_reg(`SP_ADDR_DATA, c);
        chk("m0_rx", c, e);
        wr_reg(`SP_ADDR_CONTROL, 8'h00);
        $display("test mode 0 done");
        last = e;
        rb8 = 1'b0;
        // uart modes: fixed corners, then random
        for (int t = 0; t < 8; t++)
        begin
            m = (t < 3) ? t + 1 : 1 + $urandom_range(2);
            sd = 1'($urandom);
            sm2 = (t > 4);
            tb8 = 1'($urandom);
            n9 = (t == 6) ? 1'b0 : 1'($urandom);
            st = (m == 1) ? 1'b1 : 1'($urandom);
            keep = (t == 3);
            d = 8'($urandom);
            e = 8'($urandom);
            b = bit_ns(m, sd);
            wr_reg(`SP_ADDR_POWER, {sd, 7'h00});
            wr_reg(`SP_ADDR_CONTROL, {2'(m), sm2, 1'b1, tb8, rb8, 1'b0, keep});
            fork
                u_sp_peer.recv(m == 1 ? 10 : 11, b, got);
                u_sp_peer.send(11, {st, n9, e, 1'b0}, b);
                wr_reg(`SP_ADDR_DATA, d);
            join
            wait_flag(1);
            acc = !keep && (!sm2 || n9);
            if (acc)
            begin
                rb8 = n9;
                last = e;
            end
            chk("frame", got, {1'b1, (m == 1) | tb8, d, 1'b0});
            rd_reg(`SP_ADDR_CONTROL, c);
            chk("ctl", {irq, c}, {1'b1, 2'(m), sm2, 1'b1, tb8, rb8, 1'b1, acc | keep});
            rd_reg(`SP_ADDR_DATA, c);
            chk("rx", c, last);
            $display("test %0d mode %0d done", t, m);
        end
        results();
    end
endmodule
`default_nettype wire
